// ===== rtl/mult_alu_pattern_slice.sv
// Multiply/ALU slice: pre-adder, 25x18 multiplier, three-input
// adder or logic unit with segmentation, and pattern detector.
// Assumes operands and dynamic controls come from logic on mclk_i;
// static configuration is written over an Avalon-MM slave.
//
// Local design decisions: the register offsets and the Avalon-MM interface to the registers.
`timescale 1ns/10ps
module mult_alu_pattern_slice (
  input wire logic mclk_i, // System clock, 200 MHz.
  input wire logic resetn_i, // Asynchronous reset, active low.
  input wire logic [24:0] a_i, // A operand.
  input wire logic [17:0] b_i, // B operand.
  input wire logic [47:0] c_i, // C operand, registered inside.
  input wire logic [24:0] d_i, // D operand.
  input wire logic carry_input_i, // Carry input from fabric.
  input wire logic [47:0] cascade_in_i, // Result of the adjacent slice.
  input wire logic carry_cascade_in_i, // Carry of the adjacent slice.
  input wire logic [3:0] alu_function_i, // ALU function.
  input wire logic [6:0] operand_select_i, // Operand selection.
  input wire logic [2:0] carry_source_select_i, // Carry source.
  input wire logic result_enable_i, // Result register enable.
  input wire logic result_reset_i, // Synchronous result reset.
  output logic [47:0] p_o, // Registered result.
  output logic [47:0] cascade_out_o, // Result to the adjacent slice.
  output logic [3:0] carry_out_o, // Registered segment carries.
  output logic carry_cascade_out_o, // Registered top carry.
  output logic pattern_match_flag_o, // Registered match flag.
  output logic complement_match_flag_o, // Registered complement flag.
  output logic overflow_o, // Registered overflow flag.
  output logic underflow_o, // Registered underflow flag.
  input wire logic [4:0] avs_address_i, // Avalon byte address.
  input wire logic avs_read_i, // Avalon read request.
  input wire logic avs_write_i, // Avalon write request.
  input wire logic [31:0] avs_writedata_i, // Avalon write data.
  input wire logic [3:0] avs_byteenable_i, // Avalon byte enables.
  output logic [31:0] avs_readdata_o, // Avalon read data.
  output logic avs_waitrequest_o // Avalon wait request.
);

  localparam int unsigned PW = slice_pkg::P_W;
  localparam int unsigned SW = slice_pkg::SEG_W;
  localparam int unsigned SN = slice_pkg::SEG_N;

  // The segment loop assumes the segments tile the result exactly.
  if (SW * SN != PW) begin : g_bad_seg
    $error("Segment width times count must equal result width.");
  end

  // Byte-lane merge of a bus write into a stored word.
  function automatic logic [31:0] merge_be(input logic [31:0] old_v,
                                           input logic [31:0] new_v,
                                           input logic [3:0] be);
    logic [31:0] r;
    r = old_v;
    for (int i = 0; i < 4; i++) begin
      if (be[i]) begin
        r[i*8 +: 8] = new_v[i*8 +: 8];
      end
    end
    return r;
  endfunction

  // Carry into segment k is cut when a segment boundary lies there.
  function automatic logic seg_blocked(input logic [1:0] mode,
                                       input int unsigned k);
    logic r;
    r = 1'b0;
    if (mode == slice_pkg::SIMD_FOUR12) begin
      r = 1'b1;
    end else if (mode == slice_pkg::SIMD_TWO24 && k == 2) begin
      r = 1'b1;
    end
    return r;
  endfunction

  // Reset release through two flip-flops.
  logic rst_meta;
  logic rst_n;
  always_ff @(posedge mclk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      rst_meta <= 1'b0;
      rst_n <= 1'b0;
    end else begin
      rst_meta <= 1'b1;
      rst_n <= rst_meta;
    end
  end

  // Configuration registers.
  logic [31:0] ctrl;
  logic [47:0] pattern_cfg;
  logic [47:0] mask_cfg;
  logic bus_ack;
  logic bus_req;
  logic bus_wr;
  assign bus_req = avs_read_i | avs_write_i;
  assign bus_wr = avs_write_i & bus_ack;

  // One wait state on every access keeps read data a clean register.
  assign avs_waitrequest_o = bus_req & ~bus_ack;
  always_ff @(posedge mclk_i or negedge rst_n) begin
    if (!rst_n) begin
      bus_ack <= 1'b0;
    end else begin
      bus_ack <= bus_req & ~bus_ack;
    end
  end

  // Writes land at the edge where waitrequest is low; others are dropped.
  always_ff @(posedge mclk_i or negedge rst_n) begin
    if (!rst_n) begin
      ctrl <= slice_pkg::CTRL_RESET;
      pattern_cfg <= slice_pkg::PATTERN_RESET;
      mask_cfg <= slice_pkg::MASK_RESET;
    end else if (bus_wr) begin
      case (avs_address_i)
        slice_pkg::CTRL_OFS: begin
          ctrl <= merge_be(ctrl, avs_writedata_i, avs_byteenable_i)
                  & slice_pkg::CTRL_WMASK;
        end
        slice_pkg::PAT_LO_OFS: begin
          pattern_cfg[31:0] <= merge_be(pattern_cfg[31:0],
                                        avs_writedata_i, avs_byteenable_i);
        end
        slice_pkg::PAT_HI_OFS: begin
          pattern_cfg[47:32] <= 16'(merge_be({16'h0000, pattern_cfg[47:32]},
                                avs_writedata_i, avs_byteenable_i));
        end
        slice_pkg::MASK_LO_OFS: begin
          mask_cfg[31:0] <= merge_be(mask_cfg[31:0],
                                     avs_writedata_i, avs_byteenable_i);
        end
        slice_pkg::MASK_HI_OFS: begin
          mask_cfg[47:32] <= 16'(merge_be({16'h0000, mask_cfg[47:32]},
                             avs_writedata_i, avs_byteenable_i));
        end
        default: begin
        end
      endcase
    end
  end

  // Decoded configuration fields.
  logic [1:0] preadd_mode;
  logic [1:0] simd_mode;
  logic product_pipe_reg;
  logic detector_on_setting;
  logic pattern_from_c;
  logic mask_from_c;
  logic operand_select_reg_stage;
  logic carry_select_reg_stage;
  assign preadd_mode = ctrl[slice_pkg::CTRL_PREADD_LSB +: 2];
  assign simd_mode = ctrl[slice_pkg::CTRL_SIMD_LSB +: 2];
  assign product_pipe_reg = ctrl[slice_pkg::CTRL_PIPE_BIT];
  assign detector_on_setting = ctrl[slice_pkg::CTRL_DET_BIT];
  assign pattern_from_c = ctrl[slice_pkg::CTRL_PAT_C_BIT];
  assign mask_from_c = ctrl[slice_pkg::CTRL_MASK_C_BIT];
  assign operand_select_reg_stage = ctrl[slice_pkg::CTRL_OPSEL_REG_BIT];
  assign carry_select_reg_stage = ctrl[slice_pkg::CTRL_CSEL_REG_BIT];

  // Optional registered controls and the always-registered C operand.
  logic [6:0] opsel_q;
  logic [2:0] csel_q;
  logic [47:0] c_q;
  always_ff @(posedge mclk_i or negedge rst_n) begin
    if (!rst_n) begin
      opsel_q <= 7'h00;
      csel_q <= 3'h0;
      c_q <= 48'h0000_0000_0000;
    end else begin
      opsel_q <= operand_select_i;
      csel_q <= carry_source_select_i;
      c_q <= c_i;
    end
  end

  // Both stages are expected to match so carry and operands stay aligned.
  logic [6:0] opsel;
  logic [2:0] csel;
  assign opsel = operand_select_reg_stage ? opsel_q : operand_select_i;
  assign csel = carry_select_reg_stage ? csel_q : carry_source_select_i;

  // Pre-adder; it wraps, so operands must stay within 24 signed bits.
  logic signed [24:0] pre_out;
  always_comb begin
    case (preadd_mode)
      slice_pkg::PRE_ADD: pre_out = $signed(d_i) + $signed(a_i);
      slice_pkg::PRE_SUB: pre_out = $signed(d_i) - $signed(a_i);
      slice_pkg::PRE_NEG_A: pre_out = -$signed(a_i);
      slice_pkg::PRE_BYPASS: pre_out = $signed(d_i);
      default: pre_out = $signed(d_i);
    endcase
  end

  // Two partial products: low 17 B bits, and the negative weight of B[17].
  logic signed [42:0] pp_lo;
  logic signed [42:0] pp_hi;
  always_comb begin
    pp_lo = pre_out * $signed({1'b0, b_i[16:0]});
    pp_hi = b_i[17] ? -$signed({pre_out, 17'h0}) : 43'sh0;
  end

  // Product register, bypassed when the pipe stage is off.
  logic signed [42:0] pp_lo_q;
  logic signed [42:0] pp_hi_q;
  always_ff @(posedge mclk_i or negedge rst_n) begin
    if (!rst_n) begin
      pp_lo_q <= 43'sh0;
      pp_hi_q <= 43'sh0;
    end else begin
      pp_lo_q <= pp_lo;
      pp_hi_q <= pp_hi;
    end
  end

  logic [47:0] m_lo;
  logic [47:0] m_hi;
  assign m_lo = product_pipe_reg ? 48'(pp_lo_q) : 48'(pp_lo);
  assign m_hi = product_pipe_reg ? 48'(pp_hi_q) : 48'(pp_hi);

  // Result register contents, read back by the operand multiplexers.
  logic [47:0] p;
  logic [47:0] ab;
  assign ab = {{5{a_i[24]}}, a_i, b_i};

  // X, Y and Z multiplexers.
  logic [47:0] x_mux;
  logic [47:0] y_mux;
  logic [47:0] z_mux;
  always_comb begin
    case (opsel[1:0])
      2'h0: x_mux = 48'h0000_0000_0000;
      2'h1: x_mux = m_lo;
      2'h2: x_mux = p;
      2'h3: x_mux = ab;
      default: x_mux = 48'h0000_0000_0000;
    endcase
    case (opsel[3:2])
      2'h0: y_mux = 48'h0000_0000_0000;
      2'h1: y_mux = m_hi;
      2'h2: y_mux = 48'hFFFF_FFFF_FFFF;
      2'h3: y_mux = c_q;
      default: y_mux = 48'h0000_0000_0000;
    endcase
    case (opsel[6:4])
      3'h0: z_mux = 48'h0000_0000_0000;
      3'h1: z_mux = cascade_in_i;
      3'h2: z_mux = p;
      3'h3: z_mux = c_q;
      3'h4: z_mux = p;
      3'h5: z_mux = 48'($signed(cascade_in_i) >>> 17);
      3'h6: z_mux = 48'($signed(p) >>> 17);
      default: z_mux = 48'h0000_0000_0000;
    endcase
  end

  // Carry source; feedback choices need the result register in use.
  logic carry_cascade_q;
  logic carry_in;
  always_comb begin
    case (csel)
      3'h0: carry_in = carry_input_i;
      3'h1: carry_in = ~cascade_in_i[47];
      3'h2: carry_in = carry_cascade_in_i;
      3'h3: carry_in = cascade_in_i[47];
      3'h4: carry_in = carry_cascade_q;
      3'h5: carry_in = ~p[47];
      3'h6: carry_in = a_i[24] ~^ b_i[17];
      3'h7: carry_in = p[47];
      default: carry_in = carry_input_i;
    endcase
  end

  // Subtraction as ~(~Z + X + Y + c): function bit 0 inverts Z,
  // bit 1 inverts the sum; this form survives segmentation intact.
  logic [47:0] z_op;
  logic [47:0] arith_res;
  logic [1:0] seg_carry [SN+1];
  logic [SW+1:0] seg_sum [SN];
  logic [3:0] seg_cout;
  assign z_op = z_mux ^ {48{alu_function_i[0]}};
  assign seg_carry[0] = {1'b0, carry_in};

  // Segment chain; the mode is static, the function stays dynamic.
  for (genvar k = 0; k < SN; k++) begin : g_seg
    logic [1:0] cin_k;
    assign cin_k = (k != 0 && seg_blocked(simd_mode, k)) ? 2'h0
                   : seg_carry[k];
    assign seg_sum[k] = {2'h0, x_mux[k*SW +: SW]}
                      + {2'h0, y_mux[k*SW +: SW]}
                      + {2'h0, z_op[k*SW +: SW]}
                      + {{SW{1'b0}}, cin_k};
    assign seg_carry[k+1] = seg_sum[k][SW+1:SW];
    assign arith_res[k*SW +: SW] = seg_sum[k][SW-1:0]
                                   ^ {SW{alu_function_i[1]}};
    assign seg_cout[k] = seg_sum[k][SW] ^ alu_function_i[1];
  end

  // Logic unit: bit 0 inverts Z, Y ones turns AND into OR, bit 1 inverts.
  logic [47:0] z_lg;
  logic [47:0] g_lg;
  logic [47:0] logic_res;
  logic y_ones;
  assign y_ones = (opsel[3:2] == 2'h2);
  always_comb begin
    z_lg = alu_function_i[0] ? ~z_mux : z_mux;
    if (!alu_function_i[3]) begin
      g_lg = x_mux ^ z_mux ^ {48{alu_function_i[0] ^ alu_function_i[1]}};
      logic_res = y_ones ? ~g_lg : g_lg;
    end else begin
      g_lg = y_ones ? (x_mux | z_lg) : (x_mux & z_lg);
      logic_res = alu_function_i[1] ? ~g_lg : g_lg;
    end
  end

  // Function bit 2 selects the logic unit over the adder.
  logic [47:0] alu_res;
  assign alu_res = alu_function_i[2] ? logic_res : arith_res;

  // Pattern and mask sources, each chosen on its own.
  logic [47:0] pattern_sel;
  logic [47:0] mask_sel;
  logic pd_next;
  logic pbd_next;
  assign pattern_sel = pattern_from_c ? c_q : pattern_cfg;
  assign mask_sel = mask_from_c ? c_q : mask_cfg;

  // The check looks at the next result so its flags land with it.
  pattern_match #(
    .W(48)
  ) u_detect (
    .result_i(alu_res),
    .pattern_i(pattern_sel),
    .mask_i(mask_sel),
    .match_o(pd_next),
    .complement_match_o(pbd_next)
  );

  // Result, carries and flags share one enable and one reset.
  logic pd_q;
  logic pbd_q;
  logic ovf_q;
  logic unf_q;
  logic [3:0] cout_q;
  always_ff @(posedge mclk_i or negedge rst_n) begin
    if (!rst_n) begin
      p <= 48'h0000_0000_0000;
      cout_q <= 4'h0;
      carry_cascade_q <= 1'b0;
      pd_q <= 1'b0;
      pbd_q <= 1'b0;
      ovf_q <= 1'b0;
      unf_q <= 1'b0;
    end else if (result_reset_i) begin
      p <= 48'h0000_0000_0000;
      cout_q <= 4'h0;
      carry_cascade_q <= 1'b0;
      pd_q <= 1'b0;
      pbd_q <= 1'b0;
      ovf_q <= 1'b0;
      unf_q <= 1'b0;
    end else if (result_enable_i) begin
      p <= alu_res;
      cout_q <= seg_cout;
      carry_cascade_q <= seg_cout[3];
      pd_q <= detector_on_setting & pd_next;
      pbd_q <= detector_on_setting & pbd_next;
      // Falling edges compare with the held flags, so they need the
      // result register clocking while these outputs are watched.
      ovf_q <= detector_on_setting & pd_q & ~pd_next;
      unf_q <= detector_on_setting & pbd_q & ~pbd_next;
    end
  end

  // Registered outputs.
  assign p_o = p;
  assign cascade_out_o = p;
  assign carry_out_o = cout_q;
  assign carry_cascade_out_o = carry_cascade_q;
  assign pattern_match_flag_o = pd_q;
  assign complement_match_flag_o = pbd_q;
  assign overflow_o = ovf_q;
  assign underflow_o = unf_q;

  // Read data is registered in the wait cycle; unmapped reads give zero.
  logic [31:0] status;
  assign status = {24'h000000, cout_q, unf_q, ovf_q, pbd_q, pd_q};
  always_ff @(posedge mclk_i or negedge rst_n) begin
    if (!rst_n) begin
      avs_readdata_o <= 32'h0000_0000;
    end else if (avs_read_i && !bus_ack) begin
      case (avs_address_i)
        slice_pkg::CTRL_OFS: avs_readdata_o <= ctrl;
        slice_pkg::PAT_LO_OFS: avs_readdata_o <= pattern_cfg[31:0];
        slice_pkg::PAT_HI_OFS:
          avs_readdata_o <= {16'h0000, pattern_cfg[47:32]};
        slice_pkg::MASK_LO_OFS: avs_readdata_o <= mask_cfg[31:0];
        slice_pkg::MASK_HI_OFS: avs_readdata_o <= {16'h0000, mask_cfg[47:32]};
        slice_pkg::STATUS_OFS: avs_readdata_o <= status;
        slice_pkg::RES_LO_OFS: avs_readdata_o <= p[31:0];
        slice_pkg::RES_HI_OFS: avs_readdata_o <= {16'h0000, p[47:32]};
        default: avs_readdata_o <= 32'h0000_0000;
      endcase
    end
  end

endmodule

// ===== shared/slice_pkg.sv
// Constants, register map and mode encodings of the multiply/ALU slice.
// Assumes a single clock domain; shared by the slice and its bench.
package slice_pkg;

  // Operand and result widths.
  localparam int unsigned A_W = 25;
  localparam int unsigned B_W = 18;
  localparam int unsigned D_W = 25;
  localparam int unsigned PP_W = 43;
  localparam int unsigned P_W = 48;
  localparam int unsigned SEG_W = 12;
  localparam int unsigned SEG_N = 4;
  localparam int unsigned CASCADE_SHIFT = 17;

  // Byte addresses of the control and status words.
  localparam logic [4:0] CTRL_OFS = 5'h00;
  localparam logic [4:0] PAT_LO_OFS = 5'h04;
  localparam logic [4:0] PAT_HI_OFS = 5'h08;
  localparam logic [4:0] MASK_LO_OFS = 5'h0C;
  localparam logic [4:0] MASK_HI_OFS = 5'h10;
  localparam logic [4:0] STATUS_OFS = 5'h14;
  localparam logic [4:0] RES_LO_OFS = 5'h18;
  localparam logic [4:0] RES_HI_OFS = 5'h1C;

  // Field positions inside the control word.
  localparam int unsigned CTRL_PREADD_LSB = 0;
  localparam int unsigned CTRL_SIMD_LSB = 2;
  localparam int unsigned CTRL_PIPE_BIT = 4;
  localparam int unsigned CTRL_DET_BIT = 5;
  localparam int unsigned CTRL_PAT_C_BIT = 6;
  localparam int unsigned CTRL_MASK_C_BIT = 7;
  localparam int unsigned CTRL_OPSEL_REG_BIT = 8;
  localparam int unsigned CTRL_CSEL_REG_BIT = 9;

  // Values after reset, and the writable bits of the control word.
  localparam logic [31:0] CTRL_RESET = 32'h0000_0010;
  localparam logic [31:0] CTRL_WMASK = 32'h0000_03FF;
  localparam logic [47:0] PATTERN_RESET = 48'h0000_0000_0000;
  localparam logic [47:0] MASK_RESET = 48'h3FFF_FFFF_FFFF;

  // Pre-adder modes, Gray ordered.
  typedef enum logic [1:0] {
    PRE_ADD = 2'h0,
    PRE_SUB = 2'h1,
    PRE_NEG_A = 2'h3,
    PRE_BYPASS = 2'h2
  } preadd_mode_t;

  // Adder segmentation.
  typedef enum logic [1:0] {
    SIMD_ONE48 = 2'h0,
    SIMD_TWO24 = 2'h1,
    SIMD_FOUR12 = 2'h3
  } simd_mode_t;

endpackage

// ===== rtl/pattern_match.sv
// Masked equality check of a 48-bit word against a pattern.
// Purely combinational; the caller registers the flags.
`timescale 1ns/10ps
module pattern_match #(
  parameter int unsigned W = 48
) (
  input wire logic [W-1:0] result_i, // Word under test.
  input wire logic [W-1:0] pattern_i, // Pattern to compare.
  input wire logic [W-1:0] mask_i, // Ones mark ignored bits.
  output logic match_o, // All unmasked bits equal pattern.
  output logic complement_match_o // All unmasked bits equal ~pattern.
);

  // A masked bit always counts as equal, so only unmasked bits decide.
  assign match_o = &((result_i ~^ pattern_i) | mask_i);
  assign complement_match_o = &((result_i ^ pattern_i) | mask_i);

endmodule

// ===== bench/slice_asserts.sv
// Port-level timing checks of the multiply/ALU slice.
// Assumes one clock, mclk_i, and the low reset resetn_i.
`timescale 1ns/10ps
module slice_checker (
  input wire logic mclk_i, // Clock.
  input wire logic resetn_i, // Reset.
  input wire logic result_enable_i, // Load enable.
  input wire logic result_reset_i, // Clear.
  input wire logic avs_read_i, // Read.
  input wire logic avs_write_i, // Write.
  input wire logic avs_waitrequest_o, // Stall.
  input wire logic [47:0] p_o, // Result.
  input wire logic [47:0] cascade_out_o, // Cascade.
  input wire logic [3:0] carry_out_o, // Carries.
  input wire logic carry_cascade_out_o, // Top carry.
  input wire logic pattern_match_flag_o, // Match.
  input wire logic complement_match_flag_o, // Complement.
  input wire logic overflow_o, // Overflow.
  input wire logic underflow_o // Underflow.
);
  default clocking @(posedge mclk_i);
  endclocking
  default disable iff (!resetn_i);
  // Flags must travel with the result: same enable, same clear.
  a_cascade_copy: assert property (cascade_out_o == p_o)
    else $error("cascade output differs from result");
  a_top_carry: assert property (carry_cascade_out_o == carry_out_o[3])
    else $error("top carry differs from segment carry");
  a_hold_result: assert property (!result_enable_i && !result_reset_i
    |=> $stable(p_o) && $stable(carry_out_o))
    else $error("result moved while disabled");
  a_hold_flags: assert property (!result_enable_i && !result_reset_i
    |=> $stable({pattern_match_flag_o, complement_match_flag_o,
    overflow_o, underflow_o}))
    else $error("flags moved while disabled");
  a_clear_all: assert property (result_reset_i |=> p_o == 48'h0
    && !pattern_match_flag_o && !complement_match_flag_o && !overflow_o
    && !underflow_o) else $error("clear left result or flags set");
  // A fall is judged against the flag of the previous load.
  a_overflow_fall: assert property (
    $past(result_enable_i) && !$past(result_reset_i) |-> overflow_o ==
    ($past(pattern_match_flag_o) && !pattern_match_flag_o))
    else $error("overflow not tied to match fall");
  a_underflow_fall: assert property (
    $past(result_enable_i) && !$past(result_reset_i) |-> underflow_o ==
    ($past(complement_match_flag_o) && !complement_match_flag_o))
    else $error("underflow not tied to complement fall");
  a_one_wait: assert property ((avs_read_i || avs_write_i) &&
    avs_waitrequest_o |=> !avs_waitrequest_o)
    else $error("bus stall longer than one cycle");
endmodule
bind mult_alu_pattern_slice slice_checker slice_checker_i (
  .mclk_i(mclk_i), .resetn_i(resetn_i), .result_enable_i(result_enable_i),
  .result_reset_i(result_reset_i), .avs_read_i(avs_read_i),
  .avs_write_i(avs_write_i), .avs_waitrequest_o(avs_waitrequest_o),
  .p_o(p_o), .cascade_out_o(cascade_out_o), .carry_out_o(carry_out_o),
  .carry_cascade_out_o(carry_cascade_out_o),
  .pattern_match_flag_o(pattern_match_flag_o),
  .complement_match_flag_o(complement_match_flag_o),
  .overflow_o(overflow_o), .underflow_o(underflow_o));

// ===== bench/fabric_model.sv
// Fabric logic that feeds operands and dynamic controls to the slice.
// Assumes its tasks are called from one bench process.
`timescale 1ns/10ps
module fabric_model (
  input wire logic mclk_i, // Clock.
  output logic [24:0] a_o, // A operand.
  output logic [17:0] b_o, // B operand.
  output logic [47:0] c_o, // C operand.
  output logic [24:0] d_o, // D operand.
  output logic cin_o, // Carry input.
  output logic [47:0] casc_o, // Neighbour result.
  output logic [3:0] alu_o, // ALU function.
  output logic [6:0] opsel_o, // Operand selection.
  output logic en_o, // Result enable.
  output logic rst_o // Result clear.
);
  // The result stage starts enabled since the flags rely on it.
  initial begin
    {a_o, b_o, c_o, d_o, cin_o, casc_o, alu_o, opsel_o, rst_o} = '0;
    en_o = 1'b1;
  end
  // Operands are sign-extended from 24 bits: the pre-adder cannot wrap.
  task automatic put(input logic [23:0] a, d, input logic [17:0] b,
    input logic [47:0] c, input logic carry_input, input logic [3:0] alu,
    input logic [6:0] opsel);
    @(posedge mclk_i);
    a_o <= {a[23], a};
    d_o <= {d[23], d};
    b_o <= b;
    c_o <= c;
    cin_o <= carry_input;
    alu_o <= alu;
    opsel_o <= opsel;
  endtask
  // Random enable and clear; enable ends high again.
  task automatic jitter(input int n);
    repeat (n) begin
      @(posedge mclk_i);
      en_o <= 1'($urandom);
      rst_o <= ($urandom % 6) == 0;
      c_o <= 48'({$urandom, $urandom});
      casc_o <= 48'({$urandom, $urandom});
    end
    @(posedge mclk_i);
    en_o <= 1'b1;
    rst_o <= 1'b0;
  endtask
endmodule

// ===== bench/testbench.sv
// Self-checking bench of the multiply/ALU slice.
// Assumes the fabric model drives operands; the bench drives the bus.
`timescale 1ns/10ps
module testbench;
  logic mclk_i = 1'b0;
  logic resetn_i = 1'b0;
  logic rd = 1'b0;
  logic wr = 1'b0;
  logic [4:0] adr = 5'h00;
  logic [31:0] wdat = 32'h0;
  logic [31:0] frdat, v;
  logic [24:0] fa, fd;
  logic [23:0] ra, rdv;
  logic [17:0] fb, rb;
  logic [47:0] fc, fcasc, fp, rc, x, e1, e2;
  logic [3:0] falu, fcy, alu, cy;
  logic [6:0] fop;
  logic [51:0] s;
  logic fcin, fen, frst, fpm, fcm, fov, fun, fwr;
  int error_cnt = 0;
  int tests_run = 0;
  logic [47:0] seq [8] = '{48'h0, 48'h4000_0000_0000, 48'hC000_0000_0000,
    48'hBFFF_FFFF_FFFF, 48'h3, 48'h4, 48'hFFFF_FFFF_FFFC, 48'hFFFF_FFFF_FFFB};
  mult_alu_pattern_slice mult_alu_pattern_slice_i (
    .mclk_i(mclk_i), .resetn_i(resetn_i), .a_i(fa), .b_i(fb), .c_i(fc),
    .d_i(fd), .carry_input_i(fcin), .cascade_in_i(fcasc),
    .carry_cascade_in_i(1'b0), .alu_function_i(falu),
    .operand_select_i(fop), .carry_source_select_i(3'h0),
    .result_enable_i(fen), .result_reset_i(frst), .p_o(fp),
    .cascade_out_o(), .carry_out_o(fcy), .carry_cascade_out_o(),
    .pattern_match_flag_o(fpm), .complement_match_flag_o(fcm),
    .overflow_o(fov), .underflow_o(fun), .avs_address_i(adr),
    .avs_read_i(rd), .avs_write_i(wr), .avs_writedata_i(wdat),
    .avs_byteenable_i(4'hF), .avs_readdata_o(frdat),
    .avs_waitrequest_o(fwr));
  fabric_model fabric_model_i (.mclk_i(mclk_i), .a_o(fa), .b_o(fb),
    .c_o(fc), .d_o(fd), .cin_o(fcin), .casc_o(fcasc), .alu_o(falu),
    .opsel_o(fop), .en_o(fen), .rst_o(frst));
  // A 200 MHz clock and a watchdog far beyond the planned run.
  initial begin
    forever #2.5 mclk_i = ~mclk_i;
  end
  initial begin
    #100000;
    error_cnt++;
    tally_and_finish();
  end
  task automatic chk(input string n, input logic [47:0] e, g);
    tests_run++;
    if (g !== e) begin
      error_cnt++;
      $display("wrong value %s expected %h seen %h", n, e, g);
    end
  endtask
  // One bus access, held until the stall drops at a rising edge.
  task automatic bus(input logic w, input logic [4:0] ad,
    input logic [31:0] dt, output logic [31:0] q);
    @(posedge mclk_i);
    wr <= w;
    rd <= !w;
    adr <= ad;
    wdat <= dt;
    do begin
      @(posedge mclk_i);
    end while (fwr !== 1'b0);
    q = frdat;
    wr <= 1'b0;
    rd <= 1'b0;
  endtask
  function automatic logic [47:0] prod(input int m,
    input logic [23:0] a, d, input logic [17:0] b);
    logic signed [24:0] pa, pd, pre;
    logic signed [47:0] r;
    pa = {a[23], a};
    pd = {d[23], d};
    pre = m == 0 ? pd + pa : m == 1 ? pd - pa : m == 3 ? -pa : pd;
    r = pre * $signed(b);
    return r;
  endfunction
  function automatic logic [47:0] lu(input logic [3:0] f, input logic y,
    input logic [47:0] x, z);
    logic [47:0] r;
    r = y ? x | (f[0] ? ~z : z) : x & (f[0] ? ~z : z);
    r = f[1] ? ~r : r;
    return f[3] ? r : x ^ z ^ {48{f[0] ^ f[1] ^ y}};
  endfunction
  // Sum per segment of width w, segment carries placed above the sum.
  function automatic logic [51:0] seg_add(input logic [47:0] x, z,
    input int w);
    logic [48:0] m, t;
    logic [51:0] r;
    r = '0;
    m = (49'h1 << w) - 49'h1;
    for (int i = 0; i < 48; i += w) begin
      t = ((x >> i) & m) + ((z >> i) & m);
      r[47:0] = r[47:0] | 48'((t & m) << i);
      r[47 + (i + w) / 12] = t[w];
    end
    return r;
  endfunction
  function automatic logic [47:0] hit(input logic [47:0] p, m);
    return 48'(~|(p & ~m));
  endfunction
  task automatic tally_and_finish();
    $display("comparisons %0d mismatches %0d", tests_run, error_cnt);
    if (error_cnt == 0 && tests_run > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask
  initial begin
    v = $urandom(32'h5133);
    repeat (8) @(posedge mclk_i);
    resetn_i <= 1'b1;
    repeat (3) @(posedge mclk_i);
    bus(1'b0, slice_pkg::CTRL_OFS, 32'h0, v);
    chk("ctrl", 48'(slice_pkg::CTRL_RESET), 48'(v));
    bus(1'b0, 5'h02, 32'h0, v);
    chk("hole", 48'h0, 48'(v));
    $display("register test done");
    // Every pre-adder mode, product register off and on.
    for (int k = 0; k < 8; k++) begin
      bus(1'b1, slice_pkg::CTRL_OFS, 32'h20 | ((k & 4) << 2) | (k & 3), v);
      {ra, rdv, rb} = 66'({$urandom, $urandom, $urandom});
      rc = 48'({$urandom, $urandom});
      e1 = prod(k & 3, ra, rdv, rb);
      fabric_model_i.put(ra, rdv, rb, rc, 1'b1, 4'h0, 7'h35);
      repeat (4) @(posedge mclk_i);
      chk("sum", rc + e1 + 48'h1, fp);
      fabric_model_i.put(ra, rdv, rb, rc, 1'b1, 4'h3, 7'h35);
      repeat (4) @(posedge mclk_i);
      chk("diff", rc - (e1 + 48'h1), fp);
      {ra, rb} = 42'({$urandom, $urandom});
      e2 = prod(k & 3, ra, rdv, rb);
      fabric_model_i.put(ra, rdv, rb, rc, 1'b0, 4'h0, 7'h05);
      @(posedge mclk_i);
      #1 chk("early", k > 3 ? e1 : e2, fp);
      @(posedge mclk_i);
      #1 chk("product", e2, fp);
    end
    // Logic unit on A:B and C, then adder segmentation.
    for (int i = 0; i < 19; i++) begin
      alu = i < 16 ? {i[2], 1'b1, i[1:0]} : 4'h0;
      cy = i == 16 ? 4'h8 : i == 17 ? 4'hA : 4'hF;
      if (i > 15)
        bus(1'b1, slice_pkg::CTRL_OFS, 32'h20 | ((i - 16) * 6 & 12), v);
      {ra, rb} = 42'({$urandom, $urandom});
      rc = 48'({$urandom, $urandom});
      x = {{6{ra[23]}}, ra, rb};
      fabric_model_i.put(ra, rdv, rb, rc, 1'b0, alu,
        {3'h3, i[3], 3'h3});
      repeat (3) @(posedge mclk_i);
      if (i < 16) chk("logic", lu(alu, i[3], x, rc), fp);
      else begin
        s = seg_add(x, rc, 48 >> (i - 16));
        chk("segments", s[47:0], fp);
        chk("carries", 48'(s[51:48] & cy), 48'(fcy & cy));
      end
    end
    // Flags over default mask, then a mask of two low ones.
    bus(1'b1, slice_pkg::CTRL_OFS, 32'h20, v);
    for (int i = 0; i < 8; i++) begin
      if (i == 4) bus(1'b1, slice_pkg::MASK_LO_OFS, 32'h3, v);
      if (i == 4) bus(1'b1, slice_pkg::MASK_HI_OFS, 32'h0, v);
      e1 = i < 4 ? slice_pkg::MASK_RESET : 48'h3;
      e2 = seq[i > 0 ? i - 1 : 0];
      fabric_model_i.put(ra, rdv, rb, seq[i], 1'b0, 4'h0, 7'h30);
      repeat (2) @(posedge mclk_i);
      #1 chk("result", seq[i], fp);
      chk("match", hit(seq[i], e1), 48'(fpm));
      chk("complement", hit(~seq[i], e1), 48'(fcm));
      if (i > 0) chk("overflow", hit(e2, e1) & ~hit(seq[i], e1), 48'(fov));
      if (i > 0) chk("underflow", hit(~e2, e1) & ~hit(~seq[i], e1), 48'(fun));
    end
    // Pattern from registered C, then the mask from C as well.
    for (int i = 0; i < 4; i++) begin
      bus(1'b1, slice_pkg::CTRL_OFS, i < 2 ? 32'h60 : 32'hE0, v);
      {ra, rb} = 42'({$urandom, $urandom});
      x = {{6{ra[23]}}, ra, rb};
      rc = x ^ (48'(i) << 1);
      fabric_model_i.put(ra, rdv, rb, rc, 1'b0, 4'h0, 7'h03);
      repeat (3) @(posedge mclk_i);
      e1 = i < 2 ? 48'h3 : rc;
      chk("from c", hit(x ^ rc, e1), 48'(fpm));
    end
    fabric_model_i.jitter(60);
    $display("datapath and flag tests done");
    tally_and_finish();
  end
endmodule
